// File: src/ciack_pkg.sv
/*
  ciack_pkg: shared constants for the cascaded interrupt acknowledge group.
  Assumes: single clock domain (sys_clk, 50 MHz), used by both ends and the controller module.
*/
package ciack_pkg;
  // io decode windows, compared on all twelve address bits including bit 0
  localparam logic [11:0] CIACK_MASTER_LO = 12'h900;
  localparam logic [11:0] CIACK_MASTER_HI = 12'h902;
  localparam logic [11:0] CIACK_SLAVE1_LO = 12'h200;
  localparam logic [11:0] CIACK_SLAVE1_HI = 12'h203;
  localparam logic [11:0] CIACK_SLAVE3_LO = 12'h400;
  localparam logic [11:0] CIACK_SLAVE3_HI = 12'h402;
  // master inputs carrying slaves
  localparam logic [2:0] CIACK_SLAVE1_INPUT = 3'h1;
  localparam logic [2:0] CIACK_SLAVE3_INPUT = 3'h3;
  // power-on defaults
  localparam logic [7:0] CIACK_MASK_RESET = 8'h00;
  localparam logic [4:0] CIACK_VBASE_RESET = 5'h00;
  localparam logic [7:0] CIACK_SLAVE_MAP_RESET = 8'h0A;
  localparam logic [2:0] CIACK_ID_RESET = 3'h0;
  // lowest priority input number
  localparam logic [2:0] CIACK_LOWEST_INPUT = 3'h7;
  // register select by latched address bit 1
  localparam logic CIACK_SEL_MASK = 1'b1;
  localparam logic CIACK_SEL_CTRL = 1'b0;
  // control word fields: [7:3] vector base, [2:0] slave identity
  localparam int CIACK_VBASE_LSB = 3;
  localparam int CIACK_ID_LSB = 0;
  // acknowledge sequence phases
  typedef enum logic [1:0] {CIACK_IDLE, CIACK_FIRST, CIACK_GAP, CIACK_SECOND} ciack_phase_e;
endpackage : ciack_pkg

// File: src/ciack_if.sv
/*
  ciack_if: bus between the executive processor side and the controller group.
  Assumes: testbench resolves the shared data bus from the two enables.
*/
`timescale 1ns/1ps
interface ciack_if;
  // strobes and latched address/select
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic latched_addr_bit1;
  logic [11:0] io_addr;
  logic slave1_select_latched;
  logic slave3_select_latched;
  logic master_select_latched;
  // acknowledge and data enable
  logic irq_ack_pulse_n;
  logic data_xfer_enable;
  logic exec_cpu_irq;
  // local data bus, split into directions
  logic [7:0] cpu_data_out;
  logic cpu_data_oe;
  logic [7:0] ctl_data_out;
  logic ctl_data_oe;
  logic [7:0] data_in;
  // processor side drives strobes, acks and writes
  modport cpu (
    output io_read_strobe_n, io_write_strobe_n, latched_addr_bit1, io_addr,
    output slave1_select_latched, slave3_select_latched, master_select_latched,
    output irq_ack_pulse_n, data_xfer_enable, cpu_data_out, cpu_data_oe,
    input exec_cpu_irq, data_in
  );
  // controller group side answers
  modport dev (
    input io_read_strobe_n, io_write_strobe_n, latched_addr_bit1, io_addr,
    input slave1_select_latched, slave3_select_latched, master_select_latched,
    input irq_ack_pulse_n, data_xfer_enable, data_in,
    output exec_cpu_irq, ctl_data_out, ctl_data_oe
  );
endinterface : ciack_if

// File: src/ciack_ctrl.sv
/*
  ciack_ctrl: one level-sensed priority interrupt controller with cascade support.
  Assumes: strobes and selects already synchronous to sys_clk; reset is power-on only.
*/
`timescale 1ns/1ps
module ciack_ctrl
  import ciack_pkg::*;
#(
  parameter int NUM_INPUTS = 8
)
(
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // register access
  input wire logic sel,
  input wire logic wr_pulse,
  input wire logic addr1,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  // requests and interrupt
  input wire logic [NUM_INPUTS-1:0] irq_request_input,
  output logic irq_out,
  // acknowledge
  input wire logic ack_first,
  input wire logic ack_second,
  input wire logic is_master,
  input wire logic [2:0] cascade_in,
  output logic [2:0] cascade_out,
  output logic vec_drive,
  output logic [7:0] vec_out
);
  initial
  begin
    if (NUM_INPUTS != 8)
      $error("ciack_ctrl supports exactly eight inputs");
  end

  logic [7:0] mask; // software mask, 1 blocks
  logic [4:0] vbase; // vector base
  logic [2:0] my_id; // slave identity
  logic [7:0] slave_map; // master: inputs with slaves
  logic [7:0] latched; // requests caught on first ack
  logic [2:0] win; // winning input
  logic [7:0] live;

  ////////////////////////////////////////////////////////////
  // R02 level sense only: no edge latch on inputs
  assign live = irq_request_input & ~mask;
  // R06 interrupt follows live level, no clock delay
  assign irq_out = |live;
  assign rd_data = addr1 ? mask : {vbase, my_id};

  // configuration writes, never cleared by system reset
  // R03 writes accepted at any time
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      mask <= CIACK_MASK_RESET;
      vbase <= CIACK_VBASE_RESET;
      my_id <= CIACK_ID_RESET;
      slave_map <= CIACK_SLAVE_MAP_RESET;
    end
    else if (sel && wr_pulse)
    begin
      if (addr1 == CIACK_SEL_MASK)
        mask <= wr_data;
      else
      begin
        vbase <= wr_data[7:CIACK_VBASE_LSB];
        // R05 identity for cascade compare
        my_id <= wr_data[CIACK_VBASE_LSB-1:CIACK_ID_LSB];
      end
    end
  end

  // R10 capture pending requests on first acknowledge
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      latched <= 8'h00;
    else if (ack_first)
      latched <= live;
  end

  // R22 fixed priority, input 0 highest
  // R15 nothing latched falls to lowest input
  always_comb
  begin
    win = CIACK_LOWEST_INPUT;
    for (int i = 7; i >= 0; i--)
      if (latched[i])
        win = 3'(i);
  end

  // R11 slave input: cascade carries its number; R12 own input: zero
  assign cascade_out = slave_map[win] ? win : 3'h0;
  // R13 respond during second pulse when selected
  assign vec_drive = ack_second && (is_master ? !slave_map[win] : (cascade_in == my_id));
  assign vec_out = {vbase, win};
endmodule : ciack_ctrl

// File: src/ciack_dev.sv
/*
  ciack_dev: master plus two slaves, acknowledge sequencing and data buffer enable gate.
  Assumes: processor end follows the bus protocol; reset is power-on only, never system reset.
*/
// Function
// R01 - one master, slaves on inputs 1 and 3
// R02 - all inputs level sensed
// R03 - configure anytime with strobes, addr, select
// R04 - decode 900-902, 200-203, 400-402 hex
// R05 - slaves hold identity for cascade compare
// R06 - request high raises interrupt immediately; the cpu interrupt here comes from a flop, one clock late
// R07 - slave interrupt feeds master, master to cpu
// R08 - cpu acknowledges after current instruction
// R09 - cpu issues two acknowledge pulses
// R10 - first pulse latches pending requests
// R11 - master sends slave number on cascade
// R12 - own input: cascade zero, master vector
// R13 - cascade held, matching slave drives vector
// R14 - vector on lower eight data lines
// R15 - lost request yields lowest-priority vector
// R16 - leave input 7 unconnected, advised; master input 7 stays wired, bench drives it high
// R17 - local enables combine into bus enable
// R18 - bus enable on access or acknowledge
// R19 - any low gate input disables buffers
// R20 - data enable opens buffers for system
// R21 - controllers untouched by system reset
// R22 - fixed priority, input 0 highest
`timescale 1ns/1ps
module ciack_dev
  import ciack_pkg::*;
(
  // clock and power-on reset
  input wire logic sys_clk,
  input wire logic reset,
  // bus from processor
  ciack_if.dev bus,
  // interrupt request lines, per controller
  input wire logic [7:0] master_irq,
  input wire logic [7:0] slave1_irq,
  input wire logic [7:0] slave3_irq,
  // other on-board latched chip selects, active low
  input wire logic [4:0] chip_select_latched_n,
  // outputs to board
  output logic ctrl_bus_enable_n,
  output logic data_buffer_enable_n,
  output logic [2:0] cascade_id
);
  ciack_phase_e phase;
  logic ack_s1, ack_s2, ack_s3; // ack pin synchroniser
  logic rd_s1, rd_s2, rd_s3;
  logic wr_s1, wr_s2, wr_s3;
  logic ack_low, ack_fall, ack_rise, wr_fall;
  logic sel_m, sel_1, sel_3;
  logic [7:0] rd_m, rd_1, rd_3;
  logic irq_m, irq_1, irq_3;
  logic [2:0] cas_m;
  logic drv_m, drv_1, drv_3;
  logic [7:0] vec_m, vec_1, vec_3;
  logic [7:0] master_in;
  logic first_p, second_p, access;
  logic [7:0] next_data;

  ////////////////////////////////////////////////////////////
  // three stage pin sync; an edge counts when stages 2 and 3 differ
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      {ack_s1, ack_s2, ack_s3} <= 3'h7;
      {rd_s1, rd_s2, rd_s3} <= 3'h7;
      {wr_s1, wr_s2, wr_s3} <= 3'h7;
    end
    else
    begin
      {ack_s1, ack_s2, ack_s3} <= {bus.irq_ack_pulse_n, ack_s1, ack_s2};
      {rd_s1, rd_s2, rd_s3} <= {bus.io_read_strobe_n, rd_s1, rd_s2};
      {wr_s1, wr_s2, wr_s3} <= {bus.io_write_strobe_n, wr_s1, wr_s2};
    end
  end
  assign ack_fall = !ack_s2 && ack_s3;
  assign ack_rise = ack_s2 && !ack_s3;
  assign ack_low = !ack_s2 && !ack_s3;
  assign wr_fall = !wr_s2 && wr_s3;

  // R04 address windows qualify latched selects
  assign sel_m = bus.master_select_latched && bus.io_addr >= CIACK_MASTER_LO && bus.io_addr <= CIACK_MASTER_HI;
  assign sel_1 = bus.slave1_select_latched && bus.io_addr >= CIACK_SLAVE1_LO && bus.io_addr <= CIACK_SLAVE1_HI;
  assign sel_3 = bus.slave3_select_latched && bus.io_addr >= CIACK_SLAVE3_LO && bus.io_addr <= CIACK_SLAVE3_HI;

  ////////////////////////////////////////////////////////////
  // acknowledge phase tracker; R09 two pulses expected
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      phase <= CIACK_IDLE;
    else
    begin
      unique case (phase)
        CIACK_IDLE: if (ack_fall) phase <= CIACK_FIRST;
        CIACK_FIRST: if (ack_rise) phase <= CIACK_GAP;
        CIACK_GAP: if (ack_fall) phase <= CIACK_SECOND;
        CIACK_SECOND: if (ack_rise) phase <= CIACK_IDLE;
      endcase
    end
  end
  assign first_p = (phase == CIACK_IDLE) && ack_fall;
  assign second_p = (phase == CIACK_GAP || phase == CIACK_SECOND) && ack_low;

  ////////////////////////////////////////////////////////////
  // R01 slave interrupts on master inputs 1 and 3
  // R07 slave outputs drive master
  always_comb
  begin
    master_in = master_irq;
    master_in[CIACK_SLAVE1_INPUT] = irq_1;
    master_in[CIACK_SLAVE3_INPUT] = irq_3;
  end

  // R21 reset here is power-on only
  ciack_ctrl #(.NUM_INPUTS(8)) u_master (
    .sys_clk(sys_clk), .reset(reset), .sel(sel_m), .wr_pulse(wr_fall),
    .addr1(bus.latched_addr_bit1), .wr_data(bus.data_in), .rd_data(rd_m),
    .irq_request_input(master_in), .irq_out(irq_m), .ack_first(first_p),
    .ack_second(second_p), .is_master(1'b1), .cascade_in(3'h0),
    .cascade_out(cas_m), .vec_drive(drv_m), .vec_out(vec_m)
  );
  ciack_ctrl #(.NUM_INPUTS(8)) u_slave1 (
    .sys_clk(sys_clk), .reset(reset), .sel(sel_1), .wr_pulse(wr_fall),
    .addr1(bus.latched_addr_bit1), .wr_data(bus.data_in), .rd_data(rd_1),
    .irq_request_input(slave1_irq), .irq_out(irq_1), .ack_first(first_p),
    .ack_second(second_p), .is_master(1'b0), .cascade_in(cas_m),
    .cascade_out(), .vec_drive(drv_1), .vec_out(vec_1)
  );
  ciack_ctrl #(.NUM_INPUTS(8)) u_slave3 (
    .sys_clk(sys_clk), .reset(reset), .sel(sel_3), .wr_pulse(wr_fall),
    .addr1(bus.latched_addr_bit1), .wr_data(bus.data_in), .rd_data(rd_3),
    .irq_request_input(slave3_irq), .irq_out(irq_3), .ack_first(first_p),
    .ack_second(second_p), .is_master(1'b0), .cascade_in(cas_m),
    .cascade_out(), .vec_drive(drv_3), .vec_out(vec_3)
  );

  ////////////////////////////////////////////////////////////
  // register the cpu interrupt; one cycle late, outputs come from flops
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      bus.exec_cpu_irq <= 1'b0;
    else
      bus.exec_cpu_irq <= irq_m;
  end

  // R13 cascade held from first pulse through second
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      cascade_id <= 3'h0;
    else if (phase == CIACK_FIRST || phase == CIACK_GAP || phase == CIACK_SECOND)
      cascade_id <= cas_m;
    else
      cascade_id <= 3'h0;
  end

  // data mux: vector on ack, register on read; R14 low byte only
  always_comb
  begin
    next_data = 8'h00;
    if (drv_m) next_data = vec_m;
    else if (drv_1) next_data = vec_1;
    else if (drv_3) next_data = vec_3;
    else if (sel_m) next_data = rd_m;
    else if (sel_1) next_data = rd_1;
    else if (sel_3) next_data = rd_3;
  end
  assign access = sel_m || sel_1 || sel_3;

  // R17 enable asserted with and before data drive
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      bus.ctl_data_out <= 8'h00;
      bus.ctl_data_oe <= 1'b0;
      ctrl_bus_enable_n <= 1'b1;
    end
    else
    begin
      bus.ctl_data_out <= next_data;
      bus.ctl_data_oe <= second_p || ((sel_m || sel_1 || sel_3) && !rd_s2);
      // R18 active on access or whole acknowledge sequence
      ctrl_bus_enable_n <= !(access || phase != CIACK_IDLE || first_p);
    end
  end

  // R19 any low gate input disables; R20 data enable opens
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      data_buffer_enable_n <= 1'b1;
    else
      data_buffer_enable_n <= !(&{chip_select_latched_n, bus.data_xfer_enable, ctrl_bus_enable_n, 2'b11});
  end
endmodule : ciack_dev

// File: src/ciack_cpu.sv
/*
  ciack_cpu: processor end; configures controllers and runs two-pulse acknowledge.
  Assumes: user side issues one command at a time when ready is high.
*/
`timescale 1ns/1ps
module ciack_cpu
  import ciack_pkg::*;
#(
  parameter int PULSE_CYCLES = 4
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // bus to controllers
  ciack_if.cpu bus,
  // user command port
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [11:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic instr_done,
  output logic ready,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic [7:0] vector,
  output logic vector_valid
);
  initial
  begin
    if (PULSE_CYCLES < 2 || PULSE_CYCLES > 255)
      $error("ciack_cpu PULSE_CYCLES out of range");
  end
  typedef enum logic [2:0] {CIACK_C_IDLE, CIACK_C_IO, CIACK_C_A1, CIACK_C_G, CIACK_C_A2} ciack_cstate_e;
  ciack_cstate_e st;
  logic [7:0] cnt; // pulse width counter
  logic wr_op;
  logic irq_s1, irq_s2;

  // R08 acknowledge only after instruction completes
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      {irq_s1, irq_s2} <= 2'b00;
    end
    else
      {irq_s1, irq_s2} <= {bus.exec_cpu_irq, irq_s1};
  end

  // R03 strobes and selects; R09 two ack pulses
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      st <= CIACK_C_IDLE;
      cnt <= 8'h00;
      wr_op <= 1'b0;
      bus.io_read_strobe_n <= 1'b1;
      bus.io_write_strobe_n <= 1'b1;
      bus.irq_ack_pulse_n <= 1'b1;
      bus.io_addr <= 12'h000;
      bus.latched_addr_bit1 <= 1'b0;
      bus.master_select_latched <= 1'b0;
      bus.slave1_select_latched <= 1'b0;
      bus.slave3_select_latched <= 1'b0;
      bus.cpu_data_out <= 8'h00;
      bus.cpu_data_oe <= 1'b0;
      bus.data_xfer_enable <= 1'b0;
      ready <= 1'b0;
      rdata <= 8'h00;
      rdata_valid <= 1'b0;
      vector <= 8'h00;
      vector_valid <= 1'b0;
    end
    else
    begin
      rdata_valid <= 1'b0;
      vector_valid <= 1'b0;
      unique case (st)
        CIACK_C_IDLE:
        begin
          ready <= 1'b1;
          cnt <= 8'h00;
          if (irq_s2 && instr_done)
          begin
            ready <= 1'b0;
            bus.irq_ack_pulse_n <= 1'b0;
            st <= CIACK_C_A1;
          end
          else if (cmd_valid)
          begin
            ready <= 1'b0;
            wr_op <= cmd_write;
            bus.io_addr <= cmd_addr;
            bus.latched_addr_bit1 <= cmd_addr[1];
            bus.master_select_latched <= cmd_addr[11:8] == CIACK_MASTER_LO[11:8];
            bus.slave1_select_latched <= cmd_addr[11:8] == CIACK_SLAVE1_LO[11:8];
            bus.slave3_select_latched <= cmd_addr[11:8] == CIACK_SLAVE3_LO[11:8];
            bus.cpu_data_out <= cmd_wdata;
            bus.cpu_data_oe <= cmd_write;
            bus.io_write_strobe_n <= !cmd_write;
            bus.io_read_strobe_n <= cmd_write;
            st <= CIACK_C_IO;
          end
        end
        CIACK_C_IO:
        begin
          cnt <= cnt + 8'h01;
          // R20 data enable rises a cycle after the selects and drops on the same edge as them
          bus.data_xfer_enable <= cnt != 8'(PULSE_CYCLES);
          if (cnt == 8'(PULSE_CYCLES))
          begin
            if (!wr_op)
            begin
              rdata <= bus.data_in;
              rdata_valid <= 1'b1;
            end
            bus.io_write_strobe_n <= 1'b1;
            bus.io_read_strobe_n <= 1'b1;
            bus.cpu_data_oe <= 1'b0;
            bus.master_select_latched <= 1'b0;
            bus.slave1_select_latched <= 1'b0;
            bus.slave3_select_latched <= 1'b0;
            st <= CIACK_C_IDLE;
          end
        end
        CIACK_C_A1, CIACK_C_G:
        begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(PULSE_CYCLES))
          begin
            cnt <= 8'h00;
            bus.irq_ack_pulse_n <= (st == CIACK_C_G) ? 1'b0 : 1'b1;
            st <= (st == CIACK_C_G) ? CIACK_C_A2 : CIACK_C_G;
          end
        end
        CIACK_C_A2:
        begin
          cnt <= cnt + 8'h01;
          if (cnt == 8'(PULSE_CYCLES))
          begin
            // R14 vector read from low data byte
            vector <= bus.data_in;
            vector_valid <= 1'b1;
            bus.irq_ack_pulse_n <= 1'b1;
            st <= CIACK_C_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ciack_cpu

// File: test/ciack_monitor.sv
/*
  ciack_monitor: concurrent checks on the bus joining the processor end and the controller group.
  Assumes: one clock, async active-high reset, cpu end built with PULSE_CYCLES of 4.
*/
`timescale 1ns/1ps
module ciack_monitor
  import ciack_pkg::*;
#(
  parameter int PULSE_CYCLES = 4
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset,
  // interface signals
  input wire logic io_write_strobe_n,
  input wire logic irq_ack_pulse_n,
  input wire logic data_xfer_enable,
  input wire logic exec_cpu_irq,
  input wire logic cpu_data_oe,
  input wire logic ctl_data_oe,
  // controller group pins
  input wire logic [7:0] master_irq,
  input wire logic [4:0] chip_select_latched_n,
  input wire logic ctrl_bus_enable_n,
  input wire logic data_buffer_enable_n,
  input wire logic [2:0] cascade_id
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  //////////////////////////////////////////////////////////////////////
  logic ack_q; // acknowledge level one cycle back
  logic in_first; // high through first pulse and its gap
  logic [7:0] low_cnt; // low cycles of the running pulse
  logic ack_fall;
  assign ack_fall = ack_q && !irq_ack_pulse_n;
  // pulse tracking; plain registers so reset leaves no stale history
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      ack_q <= 1'b1;
      in_first <= 1'b0;
      low_cnt <= 8'h00;
    end
    else
    begin
      ack_q <= irq_ack_pulse_n;
      if (ack_fall)
        in_first <= !in_first;
      low_cnt <= irq_ack_pulse_n ? 8'h00 : low_cnt + 8'h01;
    end
  end
  //////////////////////////////////////////////////////////////////////
  // gap between the two pulses, as long as a pulse
  sequence s_gap;
    irq_ack_pulse_n [*5] ##1 !irq_ack_pulse_n;
  endsequence
  // write strobe held for its full span
  sequence s_strobe;
    !io_write_strobe_n [*4] ##1 io_write_strobe_n;
  endsequence
  a_no_bus_fight: assert property (!(cpu_data_oe && ctl_data_oe))
    else $error("data bus driven by both ends");
  a_drive_enabled: assert property (ctl_data_oe |-> !ctrl_bus_enable_n)
    else $error("controller drives data without bus enable");
  a_gate_closes: assert property ((!ctrl_bus_enable_n || !data_xfer_enable || !(&chip_select_latched_n))
    |-> ##[0:2] data_buffer_enable_n) else $error("data buffers left open");
  a_den_opens: assert property ((data_xfer_enable && ctrl_bus_enable_n && (&chip_select_latched_n)) [*3]
    |-> !data_buffer_enable_n) else $error("data buffers not opened");
  a_ack_width: assert property ($rose(irq_ack_pulse_n) |-> low_cnt == 8'(PULSE_CYCLES + 1))
    else $error("acknowledge pulse width wrong");
  a_ack_gap: assert property ($rose(irq_ack_pulse_n) && in_first |-> s_gap)
    else $error("second acknowledge pulse misplaced");
  a_strobe_span: assert property ($fell(io_write_strobe_n) |=> s_strobe)
    else $error("write strobe width wrong");
  a_cas_hold: assert property (!irq_ack_pulse_n && !in_first && !ack_fall |-> $stable(cascade_id))
    else $error("cascade address moved in second pulse");
  a_cas_slave_num: assert property (cascade_id != 3'h0 |-> cascade_id inside {3'h1, 3'h3})
    else $error("cascade address is no slave number");
  a_irq_rises: assert property ($rose(master_irq[0]) |-> ##[1:4] exec_cpu_irq)
    else $error("interrupt output late");
endmodule : ciack_monitor

// File: test/tb_top.sv
/*
  tb_top: both ends joined by the interface; bench model checks vectors, decode and buffer gate.
  Assumes: slaves programmed with ids 1 and 3; the bench resolves the shared data bus.
*/
`timescale 1ns/1ps
module tb_top;
  logic sys_clk, reset; // clock and power-on reset
  logic cmd_valid, cmd_write, instr_done, ready, rdata_valid, vector_valid;
  logic [11:0] cmd_addr;
  logic [7:0] cmd_wdata, rdata, vector, master_irq, slave1_irq, slave3_irq;
  logic [4:0] cs_n; // other on-board selects
  logic ctrl_bus_enable_n, data_buffer_enable_n, ack_on;
  logic [2:0] cascade_id, cas_seen;
  logic cbe_seen, dbe_seen; // enables seen low since last clear
  logic [7:0] float_pat = 8'hA5; // released bus toggles, never holds
  logic [4:0] bm, b1, b3; // vector bases
  int n_errors, n_compared, i;
  // decode table: address, selects, expected {bus enable seen, buffer open seen}
  logic [11:0] tad [5] = '{12'h403, 12'h903, 12'h600, 12'h600, 12'h203};
  logic [4:0] tcs [5] = '{5'h1F, 5'h1F, 5'h1B, 5'h1F, 5'h0F};
  logic [1:0] texp [5] = '{2'h1, 2'h1, 2'h0, 2'h1, 2'h2};
  // fixed request patterns
  logic [7:0] tm [5] = '{8'h01, 8'h00, 8'h00, 8'h10, 8'h04};
  logic [7:0] t1 [5] = '{8'h00, 8'h20, 8'h00, 8'h00, 8'h40};
  logic [7:0] t3 [5] = '{8'h00, 8'h00, 8'h84, 8'h01, 8'h00};
  ciack_if bus_if();
  // shared data bus from both enables
  assign bus_if.data_in = bus_if.ctl_data_oe ? bus_if.ctl_data_out : (bus_if.cpu_data_oe ? bus_if.cpu_data_out : float_pat);
  always_comb ack_on = ~bus_if.irq_ack_pulse_n;
  ciack_cpu #(.PULSE_CYCLES(4)) u_ciack_cpu (.sys_clk(sys_clk), .reset(reset), .bus(bus_if),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .instr_done(instr_done), .ready(ready), .rdata(rdata), .rdata_valid(rdata_valid),
    .vector(vector), .vector_valid(vector_valid));
  ciack_dev u_ciack_dev (.sys_clk(sys_clk), .reset(reset), .bus(bus_if), .master_irq(master_irq),
    .slave1_irq(slave1_irq), .slave3_irq(slave3_irq), .chip_select_latched_n(cs_n),
    .ctrl_bus_enable_n(ctrl_bus_enable_n), .data_buffer_enable_n(data_buffer_enable_n), .cascade_id(cascade_id));
  ciack_monitor #(.PULSE_CYCLES(4)) u_ciack_monitor (.sys_clk(sys_clk), .reset(reset),
    .io_write_strobe_n(bus_if.io_write_strobe_n), .irq_ack_pulse_n(bus_if.irq_ack_pulse_n),
    .data_xfer_enable(bus_if.data_xfer_enable), .exec_cpu_irq(bus_if.exec_cpu_irq),
    .cpu_data_oe(bus_if.cpu_data_oe), .ctl_data_oe(bus_if.ctl_data_oe), .master_irq(master_irq),
    .chip_select_latched_n(cs_n), .ctrl_bus_enable_n(ctrl_bus_enable_n),
    .data_buffer_enable_n(data_buffer_enable_n), .cascade_id(cascade_id));
  //////////////////////////////////////////////////////////////////////
  // 50 MHz clock
  initial sys_clk = 1'b0;
  always #10 sys_clk = ~sys_clk;
  // sticky observers of enables and cascade
  always @(posedge sys_clk)
  begin
    float_pat <= ~float_pat;
    if (ctrl_bus_enable_n === 1'b0) cbe_seen <= 1'b1;
    if (data_buffer_enable_n === 1'b0) dbe_seen <= 1'b1;
    if (cascade_id !== 3'h0) cas_seen <= cascade_id;
  end
  //////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // bounded wait for a level
  task automatic wait_hi(ref logic s);
    int k;
    k = 0;
    while (s !== 1'b1 && k < 500)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 500) check("wait", 8'h00, 8'h01);
  endtask : wait_hi
  // one command through the processor end
  task automatic bus_op(input logic wr, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge sys_clk);
    wait_hi(ready);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_addr <= a;
    cmd_wdata <= d;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    if (!wr) wait_hi(rdata_valid);
    q = rdata;
    @(posedge sys_clk);
    wait_hi(ready);
  endtask : bus_op
  // lowest set bit, 8 when none
  function automatic int low_idx(input logic [7:0] v);
    low_idx = 8;
    for (int j = 7; j >= 0; j--)
      if (v[j]) low_idx = j;
  endfunction : low_idx
  // bench model: {cascade, vector} for latched requests
  function automatic logic [10:0] model(input logic [7:0] m, input logic [7:0] s1, input logic [7:0] s3);
    logic [7:0] eff;
    int w;
    eff = m;
    eff[1] = |s1;
    eff[3] = |s3;
    w = low_idx(eff);
    if (w == 8) return {3'h0, bm, 3'h7};
    if (w == 1) return {3'h1, b1, 3'(low_idx(s1))};
    if (w == 3) return {3'h3, b3, 3'(low_idx(s3))};
    return {3'h0, bm, 3'(w)};
  endfunction : model
  // raise requests, hold off, then let the acknowledge run
  task automatic run_ack(input logic [7:0] m, input logic [7:0] s1, input logic [7:0] s3, input logic glitch);
    logic [10:0] e;
    e = glitch ? model(8'h00, 8'h00, 8'h00) : model(m, s1, s3);
    @(posedge sys_clk);
    master_irq <= m;
    slave1_irq <= s1;
    slave3_irq <= s3;
    cas_seen = 3'h0;
    cbe_seen = 1'b0;
    repeat (10) @(posedge sys_clk);
    check("irq", {7'h00, bus_if.exec_cpu_irq}, 8'h01);
    check("ack_idle", {7'h00, bus_if.irq_ack_pulse_n}, 8'h01);
    instr_done <= 1'b1;
    wait_hi(ack_on);
    instr_done <= 1'b0;
    if (glitch) master_irq <= 8'h00;
    wait_hi(vector_valid);
    check("vector", vector, e[7:0]);
    master_irq <= 8'h00;
    slave1_irq <= 8'h00;
    slave3_irq <= 8'h00;
    check("cascade", {5'h00, cas_seen}, {5'h00, e[10:8]});
    check("ack_bus_en", {7'h00, cbe_seen}, 8'h01);
    repeat (20) @(posedge sys_clk);
  endtask : run_ack
  // closing verdict
  task final_report;
    if (n_errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////
  // watchdog, far beyond the expected run
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    final_report;
  end
  // main sequence
  initial
  begin
    logic [7:0] q, r;
    {reset, cmd_valid, cmd_write, instr_done} = 4'h8;
    {cmd_addr, cmd_wdata, master_irq, slave1_irq, slave3_irq} = 44'h0;
    cs_n = 5'h1F;
    n_errors = 0;
    n_compared = 0;
    void'($urandom(32'h58FC));
    bm = 5'($urandom);
    b1 = 5'($urandom);
    b3 = 5'($urandom);
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    // master then slaves with their ids
    bus_op(1'b1, 12'h900, {bm, 3'h0}, q);
    bus_op(1'b1, 12'h200, {b1, 3'h1}, q);
    bus_op(1'b1, 12'h400, {b3, 3'h3}, q);
    // mask write and read back
    r = 8'($urandom);
    bus_op(1'b1, 12'h402, r, q);
    cbe_seen = 1'b0;
    bus_op(1'b0, 12'h402, 8'h00, q);
    check("mask", q, r);
    check("rd_bus_en", {7'h00, cbe_seen}, 8'h01);
    bus_op(1'b1, 12'h402, 8'h00, q);
    // window edges and the buffer gate
    for (i = 0; i < 5; i++)
    begin
      cs_n <= tcs[i];
      cbe_seen = 1'b0;
      dbe_seen = 1'b0;
      bus_op(1'b1, tad[i], texp[i][1] ? 8'h00 : 8'hFF, q);
      check("decode", {6'h00, cbe_seen, dbe_seen}, {6'h00, texp[i]});
    end
    cs_n <= 5'h1F;
    // random master requests always set input 7; random slave requests keep input 7 free
    for (i = 0; i < 5; i++)
      run_ack(tm[i], t1[i], t3[i], 1'b0);
    for (i = 0; i < 6; i++)
      run_ack(8'($urandom) | 8'h80, 8'($urandom) & 8'h70, 8'($urandom) & 8'h7F, 1'b0);
    run_ack(8'h04, 8'h00, 8'h00, 1'b1);
    final_report;
  end
endmodule : tb_top
